// *** hdl/port_phy_control_status_regs.sv ***
// Per-port PHY control and status registers for the two PHY ports
`default_nettype none
module port_phy_control_status_regs
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Strap inputs
  input wire logic PORT1_NEGOTIATION_STRAP,
  input wire logic PORT2_NEGOTIATION_STRAP,
  input wire logic PORT1_SPEED_STRAP,
  input wire logic PORT2_SPEED_STRAP,
  input wire logic PORT1_DUPLEX_STRAP,
  input wire logic PORT2_DUPLEX_STRAP,
  input wire logic PAUSE_ADVERTISE_STRAP,
  input wire logic PORT2_CROSSOVER_DISABLE_STRAP,
  input wire logic PORT2_CROSSOVER_FORCE_STRAP,
  // Internal register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Standard management register port
  input wire logic MII_PORT,
  input wire logic [4:0] MII_REG,
  input wire logic MII_WR,
  input wire logic MII_RD,
  input wire logic [15:0] MII_WDATA,
  output logic [15:0] MII_RDATA,
  // PHY state, index 0 is port 1
  input wire logic [1:0] PHY_MDIX_STATE,
  input wire logic [1:0] PHY_AN_DONE,
  input wire logic [1:0] PHY_LINK_GOOD,
  input wire logic [1:0] PHY_SPEED_SENSE,
  input wire logic [1:0] PHY_PARTNER_PAUSE,
  input wire logic [1:0][3:0] PHY_PARTNER_ABILITY,
  input wire logic [1:0][3:0] PHY_LED,
  // PHY controls
  output logic [1:0] AN_ENABLE,
  output logic [1:0] AN_RESTART,
  output logic [1:0] SPEED_100,
  output logic [1:0] FULL_DUPLEX,
  output logic [1:0] PAUSE_ADVERTISE,
  output logic [1:0][3:0] ABILITY_ADVERTISE,
  output logic [1:0] TX_DISABLE,
  output logic [1:0] POWER_DOWN,
  output logic FAR_END_FAULT_DISABLE,
  output logic [1:0] CROSSOVER_AUTO,
  output logic [1:0] CROSSOVER_MDI,
  // LED pins
  output logic [1:0] PORT_LED_OUT_3,
  output logic [1:0] PORT_LED_OUT_2,
  output logic [1:0] PORT_LED_OUT_1,
  output logic [1:0] PORT_LED_OUT_0
);
  typedef enum logic {PH_STRAP, PH_RUN} phase_e;

  typedef struct packed {
    phase_e phase;
    logic [1:0][7:0] neg;
    logic [1:0][7:0] misc;
    logic [1:0][7:0] stat;
    logic [1:0] restart;
    logic [1:0][3:0] led;
    logic [1:0] speed;
    logic [1:0] duplex;
    logic [7:0] reg_rdata;
    logic [15:0] mii_rdata;
  } state_s;

  state_s s;
  state_s next_s;
  logic rst_n;

  reset_release u_reset_release (
    .clk(CLK),
    .rst_in_n(RESET_N),
    .rst_out_n(rst_n)
  );

  // Five ability bits into the standard advertisement layout
  function automatic logic [15:0] adv_word(input logic [4:0] pa);
    adv_word = '0;
    adv_word[MII_PAUSE_BIT] = pa[PAUSE_BIT];
    adv_word[MII_ABIL_LSB +: 4] = pa[ABIL_MSB:0];
    adv_word[4:0] = MII_SELECTOR;
  endfunction : adv_word

  logic [1:0] strap_an;
  logic [1:0] strap_spd;
  logic [1:0] strap_dpx;
  assign strap_an = {PORT2_NEGOTIATION_STRAP, PORT1_NEGOTIATION_STRAP};
  assign strap_spd = {PORT2_SPEED_STRAP, PORT1_SPEED_STRAP};
  assign strap_dpx = {PORT2_DUPLEX_STRAP, PORT1_DUPLEX_STRAP};

  always_comb begin
    logic [3:0] common;
    logic mii_sel;
    common = '0;
    mii_sel = 1'b0;
    next_s = s;
    next_s.restart = '0;
    next_s.phase = PH_RUN;
    for (int p = 0; p < PORTS; p++) begin
      mii_sel = (MII_PORT == p[0]);
      if (s.phase == PH_STRAP) begin
        next_s.neg[p][AN_EN_BIT] = strap_an[p];
        next_s.neg[p][SPD_BIT] = strap_spd[p];
        next_s.neg[p][DPX_BIT] = strap_dpx[p];
        next_s.neg[p][PAUSE_BIT] = PAUSE_ADVERTISE_STRAP;
        if (p == 1) begin
          next_s.misc[p][MDIX_DIS_BIT] = PORT2_CROSSOVER_DISABLE_STRAP;
          next_s.misc[p][FORCE_MDI_BIT] = PORT2_CROSSOVER_FORCE_STRAP;
        end
      end else begin
        // Management writes first, so the internal port wins a collision
        if (MII_WR && mii_sel) begin
          case (MII_REG)
            MII_CTRL: begin
              next_s.neg[p][AN_EN_BIT] = MII_WDATA[MII_ANEN_BIT];
              next_s.neg[p][SPD_BIT] = MII_WDATA[MII_SPD_BIT];
              next_s.neg[p][DPX_BIT] = MII_WDATA[MII_DPX_BIT];
              next_s.misc[p][PWRDN_BIT] = MII_WDATA[MII_PWRDN_BIT];
              next_s.restart[p] = MII_WDATA[MII_RESTART_BIT];
            end
            MII_ADV: begin
              next_s.neg[p][PAUSE_BIT] = MII_WDATA[MII_PAUSE_BIT];
              next_s.neg[p][ABIL_MSB:0] = MII_WDATA[MII_ABIL_LSB +: 4];
            end
            MII_VEND: begin
              next_s.misc[p] = MII_WDATA[7:0];
              next_s.misc[p][RESTART_BIT] = 1'b0;
              next_s.restart[p] = MII_WDATA[RESTART_BIT];
            end
            default: begin
            end
          endcase
        end
        if (REG_WR && REG_ADDR == NEG_OFS[p]) begin
          next_s.neg[p] = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == MISC_OFS[p]) begin
          next_s.misc[p] = REG_WDATA;
          next_s.misc[p][RESTART_BIT] = 1'b0;
          next_s.restart[p] = REG_WDATA[RESTART_BIT];
        end
      end
      // Status follows the PHY every cycle
      next_s.stat[p] = {PHY_MDIX_STATE[p], PHY_AN_DONE[p], PHY_LINK_GOOD[p],
                        PHY_PARTNER_PAUSE[p], PHY_PARTNER_ABILITY[p]};
      // LEDs blanked high or passed from the PHY
      next_s.led[p] = s.misc[p][LED_OFF_BIT] ? 4'hf : PHY_LED[p];
      // Operating speed and duplex
      common = s.neg[p][ABIL_MSB:0] & s.stat[p][ABIL_MSB:0];
      if (!s.neg[p][AN_EN_BIT]) begin
        next_s.speed[p] = s.neg[p][SPD_BIT];
        next_s.duplex[p] = s.neg[p][DPX_BIT];
      end else if (s.stat[p][ST_AN_DONE_BIT] && common != 4'h0) begin
        next_s.speed[p] = common[3] | common[2];
        next_s.duplex[p] = common[3] | (~common[2] & common[1]);
      end else begin
        next_s.speed[p] = PHY_SPEED_SENSE[p];
        next_s.duplex[p] = s.neg[p][DPX_BIT];
      end
    end
    // Internal register read, one cycle latency
    if (REG_RD) begin
      next_s.reg_rdata = '0;
      for (int p = 0; p < PORTS; p++) begin
        if (REG_ADDR == NEG_OFS[p]) begin
          next_s.reg_rdata = s.neg[p];
        end
        if (REG_ADDR == MISC_OFS[p]) begin
          next_s.reg_rdata = s.misc[p];
        end
        if (REG_ADDR == STAT_OFS[p]) begin
          next_s.reg_rdata = s.stat[p];
        end
      end
    end
    // Standard management read view
    if (MII_RD) begin
      next_s.mii_rdata = '0;
      for (int p = 0; p < PORTS; p++) begin
        if (MII_PORT == p[0]) begin
          case (MII_REG)
            MII_CTRL: begin
              next_s.mii_rdata[MII_ANEN_BIT] = s.neg[p][AN_EN_BIT];
              next_s.mii_rdata[MII_SPD_BIT] = s.neg[p][SPD_BIT];
              next_s.mii_rdata[MII_DPX_BIT] = s.neg[p][DPX_BIT];
              next_s.mii_rdata[MII_PWRDN_BIT] = s.misc[p][PWRDN_BIT];
            end
            MII_STAT: begin
              next_s.mii_rdata[MII_ANCMPL_BIT] = s.stat[p][ST_AN_DONE_BIT];
              next_s.mii_rdata[MII_LINK_BIT] = s.stat[p][ST_LINK_BIT];
            end
            MII_ADV: begin
              next_s.mii_rdata = adv_word(s.neg[p][4:0]);
            end
            MII_LPA: begin
              next_s.mii_rdata = adv_word(s.stat[p][4:0]);
            end
            MII_VEND: begin
              next_s.mii_rdata = {s.stat[p], s.misc[p]};
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s.phase <= PH_STRAP;
      s.neg <= {NEG_RST, NEG_RST};
      s.misc <= {MISC_RST, MISC_RST};
      s.stat <= {STAT_RST, STAT_RST};
      s.restart <= '0;
      s.led <= {LED_RST, LED_RST};
      s.speed <= '0;
      s.duplex <= '0;
      s.reg_rdata <= '0;
      s.mii_rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign REG_RDATA = s.reg_rdata;
  assign MII_RDATA = s.mii_rdata;
  assign AN_RESTART = s.restart;
  assign SPEED_100 = s.speed;
  assign FULL_DUPLEX = s.duplex;
  assign FAR_END_FAULT_DISABLE = s.misc[0][FEF_BIT];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      assign AN_ENABLE[g] = s.neg[g][AN_EN_BIT];
      assign PAUSE_ADVERTISE[g] = s.neg[g][PAUSE_BIT];
      assign ABILITY_ADVERTISE[g] = s.neg[g][ABIL_MSB:0];
      assign TX_DISABLE[g] = s.misc[g][TXDIS_BIT];
      assign POWER_DOWN[g] = s.misc[g][PWRDN_BIT];
      assign CROSSOVER_AUTO[g] = ~s.misc[g][MDIX_DIS_BIT];
      assign CROSSOVER_MDI[g] = s.misc[g][MDIX_DIS_BIT] & s.misc[g][FORCE_MDI_BIT];
      assign PORT_LED_OUT_3[g] = s.led[g][3];
      assign PORT_LED_OUT_2[g] = s.led[g][2];
      assign PORT_LED_OUT_1[g] = s.led[g][1];
      assign PORT_LED_OUT_0[g] = s.led[g][0];

      an_off_speed_a: assert property (
        s.phase == PH_RUN && !AN_ENABLE[g] |=> SPEED_100[g] == $past(s.neg[g][SPD_BIT]))
        else $error("forced speed not applied");
      an_off_duplex_a: assert property (
        s.phase == PH_RUN && !AN_ENABLE[g] |=> FULL_DUPLEX[g] == $past(s.neg[g][DPX_BIT]))
        else $error("forced duplex not applied");
      strap_load_a: assert property (
        rst_n && s.phase == PH_STRAP |=> AN_ENABLE[g] == $past(strap_an[g])
          && s.neg[g][SPD_BIT] == $past(strap_spd[g]) && PAUSE_ADVERTISE[g] == $past(PAUSE_ADVERTISE_STRAP))
        else $error("strap value not loaded");
      adv_write_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == NEG_OFS[g]
          |=> ABILITY_ADVERTISE[g] == $past(REG_WDATA[3:0]) && PAUSE_ADVERTISE[g] == $past(REG_WDATA[4]))
        else $error("advertised abilities not written");
      led_blank_a: assert property (
        s.misc[g][LED_OFF_BIT] |=> {PORT_LED_OUT_3[g], PORT_LED_OUT_2[g],
          PORT_LED_OUT_1[g], PORT_LED_OUT_0[g]} == 4'hf)
        else $error("blanked LEDs not high");
      tx_disable_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == MISC_OFS[g]
          |=> TX_DISABLE[g] == $past(REG_WDATA[6]) && POWER_DOWN[g] == $past(REG_WDATA[3]))
        else $error("transmit disable not written");
      restart_pulse_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == MISC_OFS[g] && REG_WDATA[5]
          |=> AN_RESTART[g] ##1 (!AN_RESTART[g] || $past(REG_WR) || $past(MII_WR)))
        else $error("restart pulse missing");
      mdi_force_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == MISC_OFS[g]
          |=> CROSSOVER_MDI[g] == ($past(REG_WDATA[2]) && $past(REG_WDATA[1])))
        else $error("MDI force not applied");
      xover_auto_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == MISC_OFS[g]
          |=> CROSSOVER_AUTO[g] == !$past(REG_WDATA[2]))
        else $error("auto crossover control not applied");
      restart_clear_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == MISC_OFS[g]
          |=> !s.misc[g][RESTART_BIT])
        else $error("restart bit not self-cleared");
      an_fail_duplex_a: assert property (
        s.phase == PH_RUN && AN_ENABLE[g] && !s.stat[g][ST_AN_DONE_BIT]
          |=> FULL_DUPLEX[g] == $past(s.neg[g][DPX_BIT]))
        else $error("fallback duplex not applied");
      status_read_a: assert property (
        REG_RD && REG_ADDR == STAT_OFS[g] |=> REG_RDATA == $past(s.stat[g]))
        else $error("status read mismatch");
      status_track_a: assert property (
        s.phase == PH_RUN |=> s.stat[g][7:5] == $past({PHY_MDIX_STATE[g], PHY_AN_DONE[g],
          PHY_LINK_GOOD[g]}) && s.stat[g][4] == $past(PHY_PARTNER_PAUSE[g]))
        else $error("status does not follow PHY");
      mii_adv_a: assert property (
        MII_RD && MII_PORT == 1'(g) && MII_REG == MII_ADV
          |=> MII_RDATA[8:5] == $past(s.neg[g][3:0]))
        else $error("management view mismatch");
      fef_write_a: assert property (
        s.phase == PH_RUN && REG_WR && REG_ADDR == MISC_OFS[0]
          |=> FAR_END_FAULT_DISABLE == $past(REG_WDATA[4]))
        else $error("far-end fault disable not written");
      reserved_read_a: assert property (
        REG_RD && REG_ADDR >= P3_RSVD_LO && REG_ADDR <= P3_RSVD_HI |=> REG_RDATA == 8'h00)
        else $error("reserved slot not zero");

      an_off_c: cover property (s.phase == PH_RUN && !AN_ENABLE[g] ##1 SPEED_100[g]);
      led_off_c: cover property (s.misc[g][LED_OFF_BIT] ##1 PORT_LED_OUT_0[g]);
      restart_c: cover property (AN_RESTART[g]);
      mii_write_c: cover property (MII_WR && MII_PORT == 1'(g) && MII_REG == MII_CTRL);
      status_c: cover property (s.stat[g][ST_AN_DONE_BIT] && s.stat[g][ST_LINK_BIT]);
    end
  endgenerate
endmodule : port_phy_control_status_regs
`default_nettype wire

// *** hdl/phy_regs_pkg.sv ***
// Constants for the per-port PHY control and status register set
`default_nettype none
package phy_regs_pkg;
  localparam int PORTS = 2;
  // Register offsets, index 0 is port 1 and index 1 is port 2
  localparam logic [7:0] NEG_OFS [0:1] = '{8'h1c, 8'h2c};
  localparam logic [7:0] MISC_OFS [0:1] = '{8'h1d, 8'h2d};
  localparam logic [7:0] STAT_OFS [0:1] = '{8'h1e, 8'h2e};
  localparam logic [7:0] P3_RSVD_LO = 8'h3c;
  localparam logic [7:0] P3_RSVD_HI = 8'h3e;
  // Negotiation control fields
  localparam int AN_EN_BIT = 7;
  localparam int SPD_BIT = 6;
  localparam int DPX_BIT = 5;
  localparam int PAUSE_BIT = 4;
  localparam int ABIL_MSB = 3;
  // Miscellaneous control fields
  localparam int LED_OFF_BIT = 7;
  localparam int TXDIS_BIT = 6;
  localparam int RESTART_BIT = 5;
  localparam int FEF_BIT = 4;
  localparam int PWRDN_BIT = 3;
  localparam int MDIX_DIS_BIT = 2;
  localparam int FORCE_MDI_BIT = 1;
  // Link status fields
  localparam int ST_MDIX_BIT = 7;
  localparam int ST_AN_DONE_BIT = 6;
  localparam int ST_LINK_BIT = 5;
  // Reset values before the straps are taken
  localparam logic [7:0] NEG_RST = 8'h0f;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] LED_RST = 4'hf;
  // Standard management register numbers
  localparam logic [4:0] MII_CTRL = 5'h00;
  localparam logic [4:0] MII_STAT = 5'h01;
  localparam logic [4:0] MII_ADV = 5'h04;
  localparam logic [4:0] MII_LPA = 5'h05;
  localparam logic [4:0] MII_VEND = 5'h1f;
  // Standard management field positions
  localparam int MII_SPD_BIT = 13;
  localparam int MII_ANEN_BIT = 12;
  localparam int MII_PWRDN_BIT = 11;
  localparam int MII_RESTART_BIT = 9;
  localparam int MII_DPX_BIT = 8;
  localparam int MII_ANCMPL_BIT = 5;
  localparam int MII_LINK_BIT = 2;
  localparam int MII_PAUSE_BIT = 10;
  localparam int MII_ABIL_LSB = 5;
  localparam logic [4:0] MII_SELECTOR = 5'h01;
endpackage : phy_regs_pkg
`default_nettype wire

// *** hdl/reset_release.sv ***
// Two-stage release of the asynchronous reset
`default_nettype none
module reset_release (
  // Clock and raw reset
  input wire logic clk,
  input wire logic rst_in_n,
  // Released reset
  output logic rst_out_n
);
  typedef struct packed {
    logic [1:0] sync;
  } state_s;

  state_s s;
  state_s next_s;

  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rst_out_n = s.sync[1];
endmodule : reset_release
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the per-port PHY control and status registers
`default_nettype none
module tb
  import phy_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic p1_neg = 1'b0, p2_neg = 1'b1, p1_spd = 1'b1, p2_spd = 1'b0, p1_dpx = 1'b0;
  logic p2_dpx = 1'b1, pause_strap = 1'b1, p2_xdis = 1'b1, p2_xfrc = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic REG_WR = 1'b0, REG_RD = 1'b0, MII_PORT = 1'b0, MII_WR = 1'b0, MII_RD = 1'b0;
  logic [4:0] MII_REG = 5'h00;
  logic [15:0] MII_WDATA = 16'h0000, MII_RDATA;
  logic [1:0] PHY_MDIX_STATE = 2'h0, PHY_AN_DONE = 2'h0, PHY_LINK_GOOD = 2'h0;
  logic [1:0] PHY_SPEED_SENSE = 2'h0, PHY_PARTNER_PAUSE = 2'h0;
  logic [1:0][3:0] PHY_PARTNER_ABILITY = 8'h00, PHY_LED = 8'h00, ABILITY_ADVERTISE;
  logic [1:0] AN_ENABLE, AN_RESTART, SPEED_100, FULL_DUPLEX, PAUSE_ADVERTISE, TX_DISABLE;
  logic [1:0] POWER_DOWN, CROSSOVER_AUTO, CROSSOVER_MDI;
  logic [1:0] PORT_LED_OUT_3, PORT_LED_OUT_2, PORT_LED_OUT_1, PORT_LED_OUT_0;
  logic FAR_END_FAULT_DISABLE;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] neg_tbl [0:3] = '{8'h00, 8'h40, 8'h20, 8'h60};
  always #10 CLK = ~CLK;
  port_phy_control_status_regs dut (.CLK(CLK), .RESET_N(RESET_N),
    .PORT1_NEGOTIATION_STRAP(p1_neg), .PORT2_NEGOTIATION_STRAP(p2_neg),
    .PORT1_SPEED_STRAP(p1_spd), .PORT2_SPEED_STRAP(p2_spd), .PORT1_DUPLEX_STRAP(p1_dpx),
    .PORT2_DUPLEX_STRAP(p2_dpx), .PAUSE_ADVERTISE_STRAP(pause_strap),
    .PORT2_CROSSOVER_DISABLE_STRAP(p2_xdis), .PORT2_CROSSOVER_FORCE_STRAP(p2_xfrc),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .MII_PORT(MII_PORT), .MII_REG(MII_REG), .MII_WR(MII_WR),
    .MII_RD(MII_RD), .MII_WDATA(MII_WDATA), .MII_RDATA(MII_RDATA),
    .PHY_MDIX_STATE(PHY_MDIX_STATE), .PHY_AN_DONE(PHY_AN_DONE), .PHY_LINK_GOOD(PHY_LINK_GOOD),
    .PHY_SPEED_SENSE(PHY_SPEED_SENSE), .PHY_PARTNER_PAUSE(PHY_PARTNER_PAUSE),
    .PHY_PARTNER_ABILITY(PHY_PARTNER_ABILITY), .PHY_LED(PHY_LED), .AN_ENABLE(AN_ENABLE),
    .AN_RESTART(AN_RESTART), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
    .PAUSE_ADVERTISE(PAUSE_ADVERTISE), .ABILITY_ADVERTISE(ABILITY_ADVERTISE),
    .TX_DISABLE(TX_DISABLE), .POWER_DOWN(POWER_DOWN),
    .FAR_END_FAULT_DISABLE(FAR_END_FAULT_DISABLE), .CROSSOVER_AUTO(CROSSOVER_AUTO),
    .CROSSOVER_MDI(CROSSOVER_MDI), .PORT_LED_OUT_3(PORT_LED_OUT_3),
    .PORT_LED_OUT_2(PORT_LED_OUT_2), .PORT_LED_OUT_1(PORT_LED_OUT_1),
    .PORT_LED_OUT_0(PORT_LED_OUT_0));
  // Compare one value and report a difference
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask : idle
  // Internal register write, one strobe cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask : reg_wr
  // Internal register read and compare
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, REG_RDATA});
    @(negedge CLK);
  endtask : reg_rd
  task automatic mii_wr(input logic p, input logic [4:0] r, input logic [15:0] d);
    MII_PORT = p;
    MII_REG = r;
    MII_WDATA = d;
    MII_WR = 1'b1;
    @(negedge CLK);
    MII_WR = 1'b0;
  endtask : mii_wr
  task automatic mii_rd(input logic p, input logic [4:0] r, input logic [15:0] exp);
    MII_PORT = p;
    MII_REG = r;
    MII_RD = 1'b1;
    @(negedge CLK);
    MII_RD = 1'b0;
    chk($sformatf("mii %0d reg %h", p, r), exp, MII_RDATA);
    @(negedge CLK);
  endtask : mii_rd
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(20 * 3000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge CLK);
    RESET_N = 1'b1;
    repeat (4) @(posedge CLK);
    idle(1);
    // Strap and fixed reset values
    reg_rd(NEG_OFS[0], 8'h5f);
    reg_rd(NEG_OFS[1], 8'hbf);
    reg_rd(MISC_OFS[0], 8'h00);
    reg_rd(MISC_OFS[1], 8'h04);
    reg_rd(STAT_OFS[0], 8'h00);
    reg_rd(STAT_OFS[1], 8'h00);
    chk("an_enable", 16'h2, {14'h0, AN_ENABLE});
    chk("speed", 16'h1, {14'h0, SPEED_100});
    chk("duplex", 16'h2, {14'h0, FULL_DUPLEX});
    chk("xover auto", 16'h1, {14'h0, CROSSOVER_AUTO});
    chk("xover mdi", 16'h0, {14'h0, CROSSOVER_MDI});
    chk("pause adv", 16'h3, {14'h0, PAUSE_ADVERTISE});
    chk("ability adv", 16'h00ff, {8'h00, ABILITY_ADVERTISE});
    // Negotiation on but not done: speed sensed, duplex forced
    PHY_SPEED_SENSE = 2'b10;
    idle(3);
    chk("p2 speed", 16'h1, {15'h0, SPEED_100[1]});
    chk("p2 duplex", 16'h1, {15'h0, FULL_DUPLEX[1]});
    // Every forced speed and duplex combination on port 1
    for (int i = 0; i < 4; i++) begin
      reg_wr(NEG_OFS[0], neg_tbl[i]);
      idle(2);
      chk("forced speed", {15'h0, neg_tbl[i][6]}, {15'h0, SPEED_100[0]});
      chk("forced duplex", {15'h0, neg_tbl[i][5]}, {15'h0, FULL_DUPLEX[0]});
      chk("adv off", 16'h0, {11'h0, PAUSE_ADVERTISE[0], ABILITY_ADVERTISE[0]});
    end
    reg_wr(NEG_OFS[0], 8'h9a);
    idle(1);
    chk("adv on", 16'h1a, {11'h0, PAUSE_ADVERTISE[0], ABILITY_ADVERTISE[0]});
    chk("an on", 16'h1, {15'h0, AN_ENABLE[0]});
    mii_rd(1'b0, MII_ADV, 16'h0541);
    // Blanking, transmit disable, far-end fault disable and power down on port 1
    PHY_LED = 8'h05;
    reg_wr(MISC_OFS[0], 8'hd8);
    idle(2);
    chk("leds off", 16'hf, {12'h0, PORT_LED_OUT_3[0], PORT_LED_OUT_2[0], PORT_LED_OUT_1[0],
      PORT_LED_OUT_0[0]});
    chk("tx dis", 16'h1, {15'h0, TX_DISABLE[0]});
    chk("fef dis", 16'h1, {15'h0, FAR_END_FAULT_DISABLE});
    chk("pwr dn", 16'h1, {15'h0, POWER_DOWN[0]});
    reg_rd(MISC_OFS[0], 8'hd8);
    reg_wr(MISC_OFS[0], 8'h00);
    idle(2);
    chk("leds on", 16'h5, {12'h0, PORT_LED_OUT_3[0], PORT_LED_OUT_2[0], PORT_LED_OUT_1[0],
      PORT_LED_OUT_0[0]});
    chk("misc clear", 16'h0, {13'h0, TX_DISABLE[0], POWER_DOWN[0], FAR_END_FAULT_DISABLE});
    // Restart pulse, self-clearing bit
    reg_wr(MISC_OFS[0], 8'h20);
    chk("restart pulse", 16'h1, {14'h0, AN_RESTART});
    idle(1);
    chk("restart end", 16'h0, {14'h0, AN_RESTART});
    reg_rd(MISC_OFS[0], 8'h00);
    // Crossover control on port 2
    reg_wr(MISC_OFS[1], 8'h06);
    idle(1);
    chk("force mdi", 16'h1, {14'h0, CROSSOVER_AUTO[1], CROSSOVER_MDI[1]});
    reg_wr(MISC_OFS[1], 8'h00);
    idle(1);
    chk("auto xover", 16'h2, {14'h0, CROSSOVER_AUTO[1], CROSSOVER_MDI[1]});
    // Status reporting, read-only
    PHY_MDIX_STATE = 2'b01;
    PHY_AN_DONE = 2'b01;
    PHY_LINK_GOOD = 2'b01;
    PHY_PARTNER_PAUSE = 2'b01;
    PHY_PARTNER_ABILITY = 8'h0a;
    idle(2);
    reg_wr(STAT_OFS[0], 8'h00);
    reg_rd(STAT_OFS[0], 8'hfa);
    reg_rd(STAT_OFS[1], 8'h00);
    mii_rd(1'b0, MII_LPA, 16'h0541);
    mii_rd(1'b0, MII_VEND, 16'hfa00);
    chk("an result", 16'h3, {14'h0, SPEED_100[0], FULL_DUPLEX[0]});
    mii_wr(1'b0, MII_CTRL, 16'h3300);
    chk("mii restart", 16'h1, {14'h0, AN_RESTART});
    mii_rd(1'b0, MII_CTRL, 16'h3100);
    mii_rd(1'b0, MII_STAT, 16'h0024);
    reg_rd(NEG_OFS[0], 8'hfa);
    // Management write reaches the port 2 misc register
    mii_wr(1'b1, MII_VEND, 16'h0048);
    idle(1);
    chk("mii misc", 16'h3, {14'h0, TX_DISABLE[1], POWER_DOWN[1]});
    reg_rd(MISC_OFS[1], 8'h48);
    // Third port slots and an unmapped place
    for (int a = 0; a < 3; a++) begin
      reg_wr(P3_RSVD_LO + 8'(a), 8'hff);
      reg_rd(P3_RSVD_LO + 8'(a), 8'h00);
    end
    reg_rd(8'h50, 8'h00);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
